// ==== pkg/rbc_pkg.sv ====
// constants, field layouts and helper functions shared by both link ends
// assumes one 20 MHz clock shared by both ends
package rbc_pkg;
	// ==========================================
	// response-time parameter byte layout
	localparam int PRM_E_HI = 7;
	localparam int PRM_E_LO = 6;
	localparam int PRM_B_HI = 5;
	localparam int PRM_B_LO = 3;
	localparam int PRM_A_HI = 2;
	localparam int PRM_A_LO = 0;
	// ==========================================
	// block element layout
	localparam int ELEM_SHORT_BIT = 7;
	localparam int ACC_HI = 6;
	localparam int ACC_LO = 4;
	localparam int MODE_Z_HI = 7;
	localparam int MODE_Z_LO = 3;
	localparam int MODE_TUNNEL_BIT = 2;
	localparam int MODE_ENC_BIT = 1;
	localparam int MODE_FAMILY_BIT = 0;
	localparam logic [2:0] MODE_PLAIN_RF = 3'h0;
	localparam logic [7:0] ELEM_SHORT_HEAD = 8'h80;
	localparam logic [7:0] ELEM_LONG_HEAD = 8'h00;
	localparam int BLOCK_SHIFT = 4;
	// ==========================================
	// response time descriptor
	localparam int DESC_LEN = 8;
	localparam int DESC_READ_IDX = 5;
	localparam int DESC_WRITE_IDX = 6;
	localparam int DESC_ZERO_FIRST = 2;
	localparam int DESC_ZERO_LAST = 4;
	localparam logic [7:0] DESC_FILL = 8'hff;
	localparam logic [7:0] DESC_ZERO = 8'h00;
	// ==========================================
	// limits
	localparam logic [7:0] READ_MAX_SVC = 8'h0f;
	localparam logic [7:0] WRITE_MAX_SVC = 8'h0b;
	localparam logic [7:0] READ_MAX_BLK = 8'h0f;
	localparam logic [7:0] WRITE_MAX_BLK_FEW = 8'h0c;
	localparam logic [7:0] WRITE_MAX_BLK_MANY = 8'h0b;
	localparam logic [7:0] WRITE_FEW_SVC = 8'h08;
	localparam logic [7:0] ENC_PARAM_BLK = 8'h02;
	localparam int MAX_BLK = 15;
	// ==========================================
	// frame codes and status bits
	localparam logic [7:0] CMD_POLL = 8'h00;
	localparam logic [7:0] CMD_READ = 8'h06;
	localparam logic [7:0] CMD_WRITE = 8'h08;
	localparam logic [7:0] RSP_OFFSET = 8'h01;
	localparam logic [7:0] SLOT_FIRST = 8'h00;
	localparam int RSP_HDR_LEN = 2;
	localparam int POLL_RSP_LEN = RSP_HDR_LEN + DESC_LEN;
	localparam int ERR_SVC_CNT = 0;
	localparam int ERR_SVC_DIFF = 1;
	localparam int ERR_ELEM = 2;
	localparam int ERR_MODE_DIFF = 3;
	localparam int ERR_BLK_CNT = 4;
	localparam int ERR_FRAME = 5;
	// ==========================================
	// timing: one unit T is 256 x 16 carrier periods
	localparam longint T_CARRIER_PERIODS = 256 * 16;
	localparam longint FC_HZ = 64'd13560000;
	localparam longint CLK_HZ = 64'd20000000;
	localparam int T_CYCLES = int'((T_CARRIER_PERIODS * CLK_HZ) / FC_HZ);
	localparam logic [19:0] POLL_WAIT_UNITS = 20'h00001;
	// ==========================================
	// controller register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_SVC = 8'h04;
	localparam logic [7:0] REG_SHAPE = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_TIMING = 8'h10;

	function automatic logic [19:0] resp_units(input logic [7:0] prm, input logic [7:0] n);
		logic [19:0] base;
		base = (20'(prm[PRM_B_HI:PRM_B_LO]) + 20'h1) * 20'(n) + 20'(prm[PRM_A_HI:PRM_A_LO]) + 20'h1;
		return base << (2 * prm[PRM_E_HI:PRM_E_LO]);
	endfunction

	function automatic logic [7:0] max_svc(input logic is_write);
		return is_write ? WRITE_MAX_SVC : READ_MAX_SVC;
	endfunction

	function automatic logic [7:0] max_blk(input logic is_write, input logic [7:0] svc);
		if (!is_write) begin
			return READ_MAX_BLK;
		end
		return (svc <= WRITE_FEW_SVC) ? WRITE_MAX_BLK_FEW : WRITE_MAX_BLK_MANY;
	endfunction
endpackage

// ==== pkg/rbc_if.sv ====
// byte link between reader end and tag end
// assumes both ends clocked by the same clock_in
`timescale 1ns/1ps
interface rbc_if;
	logic cmd_valid;
	logic [7:0] cmd_data;
	logic cmd_last;
	logic rsp_valid;
	logic [7:0] rsp_data;
	logic rsp_last;
	modport tag(input cmd_valid, input cmd_data, input cmd_last,
		output rsp_valid, output rsp_data, output rsp_last);
	modport reader(output cmd_valid, output cmd_data, output cmd_last,
		input rsp_valid, input rsp_data, input rsp_last);
endinterface

// ==== verilog/rbc_tag.sv ====
// tag end: parses command frames, checks parameters, issues block accesses, answers
// assumes one byte per cycle on the link and a half-duplex reader
//
// Overview of operation
// - parameter byte is E[7:6], B[5:3], A[2:0]
// - descriptor byte 5 READ, byte 6 WRITE
// - wait = T*((B+1)n+(A+1))*4^E, T=4096/fc
// - n is block count of command
// - always answer in first time slot
// - services at most 15 READ, 11 WRITE
// - all listed services equal, else error
// - memory addressed in 16-byte blocks
// - access-mode bits 6..4 must be zero
// - bit7 set: two-byte element, byte 1 block
// - bit7 clear: three-byte element with mode byte
// - third byte bits 7..3 must be zero
// - mode bits: tunnel, encrypted, family key
// - family set without encrypted is rejected
// - READ at most 15 blocks, any mode
// - WRITE 12 blocks to 8 services, else 11
// - encrypted data blocks are count minus two
// - descriptor FFh bytes 0,1,7, 00h 2-4
// - all elements share one mode, else error
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module rbc_tag import rbc_pkg::*; #(
	parameter int MAX_BLOCKS = MAX_BLK
) (
	input wire logic clock_in,
	input wire logic rstn_in,
	rbc_if.tag link,
	input wire logic [7:0] read_param_in,
	input wire logic [7:0] write_param_in,
	output logic acc_valid_out,
	output logic acc_write_out,
	output logic [7:0] acc_block_out,
	output logic [11:0] acc_addr_out,
	output logic [2:0] acc_mode_out,
	output logic acc_tunnel_out,
	output logic acc_encrypted_out,
	output logic acc_family_out,
	output logic [7:0] data_blocks_out,
	output logic err_out
);
	localparam int IW = $clog2(MAX_BLOCKS);
	typedef enum logic [3:0] {T_CMD, T_SLOT, T_SCNT, T_SLO, T_SHI, T_BCNT, T_E0, T_E1, T_E2, T_DRAIN,
		T_DECIDE, T_ISSUE, T_RESP} rbc_tstate_e;
	rbc_tstate_e state, next_state;
	logic [7:0] cmd, svc_cnt, svc_idx, svc_lo, blk_cnt, blk_idx, elem0, errs, new_err, iss_idx, d;
	logic [15:0] svc_first;
	logic [2:0] mode_first, elem_mode;
	logic [7:0] blk_list [MAX_BLOCKS];
	logic [3:0] rsp_idx, rsp_len;
	logic receiving, last_elem, elem_done, is_write, enc_short, issue_ok;
	// descriptor byte i
	function automatic logic [7:0] desc_byte(input logic [3:0] i, input logic [7:0] rp, input logic [7:0] wp);
		if (i == 4'(DESC_READ_IDX)) begin
			return rp;
		end
		if (i == 4'(DESC_WRITE_IDX)) begin
			return wp;
		end
		if (i >= 4'(DESC_ZERO_FIRST) && i <= 4'(DESC_ZERO_LAST)) begin
			return DESC_ZERO;
		end
		return DESC_FILL;
	endfunction
	assign d = link.cmd_data;
	assign receiving = (state != T_DECIDE) && (state != T_ISSUE) && (state != T_RESP);
	assign last_elem = (9'(blk_idx) + 9'h1) >= {1'b0, blk_cnt};
	assign is_write = (cmd == CMD_WRITE);
	assign elem_done = link.cmd_valid && ((state == T_E1 && elem0[ELEM_SHORT_BIT]) || state == T_E2);
	assign elem_mode = (state == T_E2) ? d[2:0] : MODE_PLAIN_RF;
	assign enc_short = mode_first[MODE_ENC_BIT] && (blk_cnt <= ENC_PARAM_BLK);
	assign issue_ok = (errs == 8'h00) && !enc_short && (cmd != CMD_POLL);
	assign rsp_len = (cmd == CMD_POLL) ? 4'(POLL_RSP_LEN) : 4'(RSP_HDR_LEN);
	// ==========================================
	// byte parser next state
	always_comb begin
		next_state = state;
		if (link.cmd_valid) begin
			case (state)
				T_CMD: begin
					if (d == CMD_POLL) begin
						next_state = T_SLOT;
					end else if (d == CMD_READ || d == CMD_WRITE) begin
						next_state = T_SCNT;
					end else begin
						next_state = T_DRAIN;
					end
				end
				T_SLOT: next_state = T_DRAIN;
				T_SCNT: next_state = (d == 8'h00) ? T_BCNT : T_SLO;
				T_SLO: next_state = T_SHI;
				T_SHI: next_state = ((9'(svc_idx) + 9'h1) >= {1'b0, svc_cnt}) ? T_BCNT : T_SLO;
				T_BCNT: next_state = (d == 8'h00) ? T_DRAIN : T_E0;
				T_E0: next_state = T_E1;
				T_E1: begin
					if (elem0[ELEM_SHORT_BIT]) begin
						next_state = last_elem ? T_DRAIN : T_E0;
					end else begin
						next_state = T_E2;
					end
				end
				T_E2: next_state = last_elem ? T_DRAIN : T_E0;
				default: next_state = state;
			endcase
		end
	end
	// ==========================================
	// error detection
	always_comb begin
		new_err = 8'h00;
		if (link.cmd_valid && receiving) begin
			case (state)
				T_CMD: new_err[ERR_FRAME] = (d != CMD_POLL) && (d != CMD_READ) && (d != CMD_WRITE);
				T_SCNT: new_err[ERR_SVC_CNT] = (d == 8'h00) || (d > max_svc(is_write));
				T_SHI: new_err[ERR_SVC_DIFF] = (svc_idx != 8'h00) && ({d, svc_lo} != svc_first);
				T_BCNT: new_err[ERR_BLK_CNT] = (d == 8'h00) || (d > max_blk(is_write, svc_cnt));
				T_E0: new_err[ERR_ELEM] = (d[ACC_HI:ACC_LO] != 3'h0);
				T_E2: new_err[ERR_ELEM] = (d[MODE_Z_HI:MODE_Z_LO] != 5'h00)
					|| (!d[MODE_ENC_BIT] && d[MODE_FAMILY_BIT]);
				default: new_err = 8'h00;
			endcase
			if (elem_done && blk_idx != 8'h00 && elem_mode != mode_first) begin
				new_err[ERR_MODE_DIFF] = 1'b1;
			end
			if (link.cmd_last && next_state != T_DRAIN) begin
				new_err[ERR_FRAME] = 1'b1;
			end
		end
		if (state == T_DECIDE && enc_short) begin
			new_err[ERR_BLK_CNT] = 1'b1;
		end
	end
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			errs <= 8'h00;
		end else if (state == T_RESP && rsp_idx == rsp_len - 4'h1) begin
			errs <= 8'h00;
		end else begin
			errs <= errs | new_err;
		end
	end
	// ==========================================
	// control state
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state <= T_CMD;
		end else begin
			case (state)
				T_DECIDE: state <= issue_ok ? T_ISSUE : T_RESP;
				T_ISSUE: state <= ((9'(iss_idx) + 9'h1) >= {1'b0, blk_cnt}) ? T_RESP : T_ISSUE;
				T_RESP: state <= (rsp_idx == rsp_len - 4'h1) ? T_CMD : T_RESP;
				default: begin
					if (link.cmd_valid) begin
						state <= link.cmd_last ? T_DECIDE : next_state;
					end
				end
			endcase
		end
	end
	// ==========================================
	// parsed fields
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cmd <= CMD_POLL;
			svc_cnt <= 8'h00;
			svc_idx <= 8'h00;
			svc_lo <= 8'h00;
			svc_first <= 16'h0000;
			blk_cnt <= 8'h00;
			blk_idx <= 8'h00;
			elem0 <= 8'h00;
			mode_first <= MODE_PLAIN_RF;
		end else if (link.cmd_valid && receiving) begin
			case (state)
				T_CMD: begin
					cmd <= d;
					svc_cnt <= 8'h00;
					svc_idx <= 8'h00;
					blk_cnt <= 8'h00;
					blk_idx <= 8'h00;
					mode_first <= MODE_PLAIN_RF;
				end
				T_SCNT: svc_cnt <= d;
				T_SLO: svc_lo <= d;
				T_SHI: begin
					if (svc_idx == 8'h00) begin
						svc_first <= {d, svc_lo};
					end
					svc_idx <= svc_idx + 8'h01;
				end
				T_BCNT: blk_cnt <= d;
				T_E0: elem0 <= d;
				default: ;
			endcase
			if (elem_done) begin
				if (blk_idx == 8'h00) begin
					mode_first <= elem_mode;
				end
				blk_idx <= blk_idx + 8'h01;
			end
		end
	end
	always_ff @(posedge clock_in) begin
		if (link.cmd_valid && state == T_E1 && blk_idx < 8'(MAX_BLOCKS)) begin
			blk_list[IW'(blk_idx)] <= d;
		end
	end
	// ==========================================
	// block access issue
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			iss_idx <= 8'h00;
			acc_valid_out <= 1'b0;
			acc_write_out <= 1'b0;
			acc_block_out <= 8'h00;
			acc_addr_out <= 12'h000;
			acc_mode_out <= MODE_PLAIN_RF;
			acc_tunnel_out <= 1'b0;
			acc_encrypted_out <= 1'b0;
			acc_family_out <= 1'b0;
			data_blocks_out <= 8'h00;
			err_out <= 1'b0;
		end else begin
			acc_valid_out <= 1'b0;
			err_out <= 1'b0;
			if (state == T_DECIDE) begin
				iss_idx <= 8'h00;
				err_out <= !issue_ok && (cmd != CMD_POLL);
				data_blocks_out <= mode_first[MODE_ENC_BIT] ? blk_cnt - ENC_PARAM_BLK : blk_cnt;
			end else if (state == T_ISSUE) begin
				iss_idx <= iss_idx + 8'h01;
				acc_valid_out <= 1'b1;
				acc_write_out <= is_write;
				acc_block_out <= blk_list[IW'(iss_idx)];
				acc_addr_out <= 12'(blk_list[IW'(iss_idx)]) << BLOCK_SHIFT;
				acc_mode_out <= mode_first;
				acc_tunnel_out <= mode_first[MODE_TUNNEL_BIT];
				acc_encrypted_out <= mode_first[MODE_ENC_BIT];
				acc_family_out <= mode_first[MODE_FAMILY_BIT];
			end
		end
	end
	// ==========================================
	// response frame
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rsp_idx <= 4'h0;
			link.rsp_valid <= 1'b0;
			link.rsp_data <= 8'h00;
			link.rsp_last <= 1'b0;
		end else if (state == T_RESP) begin
			rsp_idx <= (rsp_idx == rsp_len - 4'h1) ? 4'h0 : rsp_idx + 4'h1;
			link.rsp_valid <= 1'b1;
			link.rsp_last <= (rsp_idx == rsp_len - 4'h1);
			if (rsp_idx == 4'h0) begin
				link.rsp_data <= cmd + RSP_OFFSET;
			end else if (rsp_idx == 4'h1) begin
				link.rsp_data <= (cmd == CMD_POLL) ? SLOT_FIRST : errs | new_err;
			end else begin
				link.rsp_data <= desc_byte(rsp_idx - 4'(RSP_HDR_LEN), read_param_in, write_param_in);
			end
		end else begin
			link.rsp_valid <= 1'b0;
			link.rsp_last <= 1'b0;
		end
	end
endmodule

// ==== verilog/rbc_reader.sv ====
// reader end: builds command frames from registers and times the answer
// assumes a simple register port driven by software, one clock shared with the tag
`timescale 1ns/1ps
module rbc_reader import rbc_pkg::*; #(
	parameter int T_CYC = T_CYCLES
) (
	input wire logic clock_in,
	input wire logic rstn_in,
	rbc_if.reader link,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out
);
	typedef enum logic [3:0] {R_IDLE, R_SLOTS, R_SCNT, R_SVLO, R_SVHI, R_BCNT, R_E0, R_E1, R_E2,
		R_WAIT} rbc_rstate_e;

	rbc_rstate_e state;
	logic [7:0] slots;
	logic [15:0] svc;
	logic [7:0] scnt;
	logic [7:0] bcnt;
	logic [2:0] mode;
	logic [7:0] base;
	logic [7:0] cmd;
	logic [7:0] sidx;
	logic [7:0] bidx;
	logic [3:0] ridx;
	logic [19:0] units;
	logic [19:0] wait_units;
	logic [31:0] cyc;
	logic done;
	logic refused;
	logic tmo;
	logic [7:0] status;
	logic [7:0] rparam;
	logic [7:0] wparam;
	logic start;
	logic [7:0] kind;
	logic bad;
	logic last_b;

	assign start = wr_in && (addr_in == REG_CTRL) && (wdata_in[1:0] != 2'h0) && (state == R_IDLE);
	assign kind = (wdata_in[1:0] == 2'h1) ? CMD_POLL : (wdata_in[1:0] == 2'h2) ? CMD_READ : CMD_WRITE;
	assign last_b = (9'(bidx) + 9'h1) >= {1'b0, bcnt};

	// refuse frames the tag would reject
	always_comb begin
		bad = 1'b0;
		if (kind != CMD_POLL) begin
			bad = (scnt == 8'h00) || (scnt > max_svc(kind == CMD_WRITE))
				|| (bcnt == 8'h00) || (bcnt > max_blk(kind == CMD_WRITE, scnt))
				|| (!mode[MODE_ENC_BIT] && mode[MODE_FAMILY_BIT])
				|| (mode[MODE_ENC_BIT] && bcnt <= ENC_PARAM_BLK);
		end
	end

	// ==========================================
	// configuration registers
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			slots <= 8'h00;
			svc <= 16'h0000;
			scnt <= 8'h01;
			bcnt <= 8'h01;
			mode <= MODE_PLAIN_RF;
			base <= 8'h00;
		end else if (wr_in && state == R_IDLE) begin
			if (addr_in == REG_CTRL) begin
				slots <= wdata_in[15:8];
			end else if (addr_in == REG_SVC) begin
				svc <= wdata_in[15:0];
			end else if (addr_in == REG_SHAPE) begin
				scnt <= wdata_in[7:0];
				bcnt <= wdata_in[15:8];
				mode <= wdata_in[18:16];
				base <= wdata_in[31:24];
			end
		end
	end

	// ==========================================
	// frame sender and answer timer
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state <= R_IDLE;
			cmd <= CMD_POLL;
			sidx <= 8'h00;
			bidx <= 8'h00;
			ridx <= 4'h0;
			units <= 20'h00000;
			wait_units <= 20'h00000;
			cyc <= 32'h0;
			done <= 1'b0;
			refused <= 1'b0;
			tmo <= 1'b0;
			status <= 8'h00;
			rparam <= 8'h00;
			wparam <= 8'h00;
			link.cmd_valid <= 1'b0;
			link.cmd_data <= 8'h00;
			link.cmd_last <= 1'b0;
		end else begin
			link.cmd_valid <= 1'b1;
			link.cmd_last <= 1'b0;
			case (state)
				R_IDLE: begin
					link.cmd_valid <= 1'b0;
					if (start) begin
						done <= 1'b0;
						tmo <= 1'b0;
						refused <= bad;
						sidx <= 8'h00;
						bidx <= 8'h00;
						ridx <= 4'h0;
						cyc <= 32'h0;
						cmd <= kind;
						if (!bad) begin
							link.cmd_valid <= 1'b1;
							link.cmd_data <= kind;
							state <= (kind == CMD_POLL) ? R_SLOTS : R_SCNT;
							units <= (kind == CMD_POLL) ? POLL_WAIT_UNITS
								: resp_units((kind == CMD_WRITE) ? wparam : rparam, bcnt);
							wait_units <= (kind == CMD_POLL) ? POLL_WAIT_UNITS
								: resp_units((kind == CMD_WRITE) ? wparam : rparam, bcnt);
						end
					end
				end
				R_SLOTS: begin
					link.cmd_data <= slots;
					link.cmd_last <= 1'b1;
					state <= R_WAIT;
				end
				R_SCNT: begin
					link.cmd_data <= scnt;
					state <= R_SVLO;
				end
				R_SVLO: begin
					link.cmd_data <= svc[7:0];
					state <= R_SVHI;
				end
				R_SVHI: begin
					link.cmd_data <= svc[15:8];
					sidx <= sidx + 8'h01;
					state <= ((9'(sidx) + 9'h1) >= {1'b0, scnt}) ? R_BCNT : R_SVLO;
				end
				R_BCNT: begin
					link.cmd_data <= bcnt;
					state <= R_E0;
				end
				R_E0: begin
					link.cmd_data <= (mode == MODE_PLAIN_RF) ? ELEM_SHORT_HEAD : ELEM_LONG_HEAD;
					state <= R_E1;
				end
				R_E1: begin
					link.cmd_data <= base + bidx;
					if (mode == MODE_PLAIN_RF) begin
						link.cmd_last <= last_b;
						bidx <= bidx + 8'h01;
						state <= last_b ? R_WAIT : R_E0;
					end else begin
						state <= R_E2;
					end
				end
				R_E2: begin
					link.cmd_data <= {5'h00, mode};
					link.cmd_last <= last_b;
					bidx <= bidx + 8'h01;
					state <= last_b ? R_WAIT : R_E0;
				end
				R_WAIT: begin
					link.cmd_valid <= 1'b0;
					if (link.rsp_valid) begin
						ridx <= ridx + 4'h1;
						if (ridx == 4'h1) begin
							status <= link.rsp_data;
						end
						if (cmd == CMD_POLL && ridx == 4'(RSP_HDR_LEN + DESC_READ_IDX)) begin
							rparam <= link.rsp_data;
						end
						if (cmd == CMD_POLL && ridx == 4'(RSP_HDR_LEN + DESC_WRITE_IDX)) begin
							wparam <= link.rsp_data;
						end
						if (link.rsp_last) begin
							done <= 1'b1;
							state <= R_IDLE;
						end
					end else if (cyc == 32'(T_CYC - 1)) begin
						cyc <= 32'h0;
						units <= units - 20'h1;
						if (units <= 20'h1) begin
							tmo <= 1'b1;
							state <= R_IDLE;
						end
					end else begin
						cyc <= cyc + 32'h1;
					end
				end
				default: state <= R_IDLE;
			endcase
		end
	end

	// ==========================================
	// register read port
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rdata_out <= 32'h0;
		end else if (rd_in) begin
			case (addr_in)
				REG_CTRL: rdata_out <= {16'h0000, slots, 8'h00};
				REG_SVC: rdata_out <= {16'h0000, svc};
				REG_SHAPE: rdata_out <= {base, 5'h00, mode, bcnt, scnt};
				REG_STATUS: rdata_out <= {16'h0000, status, 4'h0, tmo, refused, done, state != R_IDLE};
				REG_TIMING: rdata_out <= {wait_units[15:0], wparam, rparam};
				default: rdata_out <= 32'h0;
			endcase
		end else begin
			rdata_out <= 32'h0;
		end
	end
endmodule

// ==== tb/rbc_properties.sv ====
// link properties of the tag end
// assumes one clock; placed beside the reader-tag link
`timescale 1ns/1ps
module rbc_properties import rbc_pkg::*; (
	input wire logic clock_in,
	input wire logic rstn_in,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_data,
	input wire logic cmd_last,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_data,
	input wire logic rsp_last,
	input wire logic [7:0] read_param_in,
	input wire logic [7:0] write_param_in
);
	logic first;
	logic [7:0] kind;
	logic [4:0] lat;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rstn_in);
	// ==========
	// frame kind and cycles since last byte
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			first <= 1'b1;
			kind <= 8'h00;
		end else if (cmd_valid) begin
			first <= cmd_last;
			if (first) begin
				kind <= cmd_data;
			end
		end
	end
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			lat <= 5'h1f;
		end else if (cmd_valid && cmd_last) begin
			lat <= 5'h01;
		end else if (lat != 5'h1f) begin
			lat <= lat + 5'h01;
		end
	end
	// ==========
	// properties
	property p_first_slot;
		cmd_valid && cmd_last && kind == CMD_POLL |=> !rsp_valid ##1 !rsp_valid ##1 rsp_valid && rsp_data == 8'h01
			##1 rsp_data == SLOT_FIRST;
	endproperty
	a_first_slot: assert property (p_first_slot) else $error("poll answer late");
	property p_desc;
		$rose(rsp_valid) && rsp_data == 8'h01 |=> ##1 rsp_data == DESC_FILL [*2] ##1 rsp_data == DESC_ZERO [*3]
			##3 rsp_data == DESC_FILL && rsp_last;
	endproperty
	a_desc: assert property (p_desc) else $error("descriptor bytes wrong");
	property p_desc_prm;
		$rose(rsp_valid) && rsp_data == 8'h01 |-> ##7 rsp_data == read_param_in ##1 rsp_data == write_param_in;
	endproperty
	a_desc_prm: assert property (p_desc_prm) else $error("timing bytes wrong");
	property p_reject;
		$rose(rsp_valid) && kind != CMD_POLL |=> (rsp_data != 8'h00) == (lat == 5'h04);
	endproperty
	a_reject: assert property (p_reject) else $error("reject timing wrong");
	property p_read_max;
		$rose(rsp_valid) && kind == CMD_READ |-> lat <= 5'h12;
	endproperty
	a_read_max: assert property (p_read_max) else $error("too many read blocks");
	property p_write_max;
		$rose(rsp_valid) && kind == CMD_WRITE |-> lat <= 5'h0f;
	endproperty
	a_write_max: assert property (p_write_max) else $error("too many write blocks");
	property p_quiet;
		cmd_valid && cmd_last |=> !rsp_valid;
	endproperty
	a_quiet: assert property (p_quiet) else $error("answer before decide");
	property p_code;
		$rose(rsp_valid) |-> rsp_data == kind + RSP_OFFSET;
	endproperty
	a_code: assert property (p_code) else $error("answer code wrong");
endmodule

// ==== tb/rbc_tb_top.sv ====
// bench: reader and tag on one link, a second tag driven raw
// assumes package, interface and both ends compiled first
`timescale 1ns/1ps
module rbc_tb_top import rbc_pkg::*;;
	logic clock_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata, r;
	logic [7:0] rprm = 8'h5a;
	logic [7:0] wprm = 8'h47;
	logic a1v, a1w, a2v, a2t, a2e, a2f, e2, lw1, bad;
	logic [11:0] a1a, a2a, la1, la2;
	logic [2:0] a2m;
	logic [7:0] d1, d2, a2b, lb2;
	int err_total = 0;
	int checks_done = 0;
	int n1 = 0;
	int n2 = 0;
	int ne = 0;
	int b, m;
	rbc_if lk();
	rbc_if lk2();
	always #25 clock_in = ~clock_in;
	rbc_reader #(.T_CYC(8)) u_rbc_reader (.clock_in(clock_in), .rstn_in(rstn_in), .link(lk), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata));
	rbc_tag u_rbc_tag (.clock_in(clock_in), .rstn_in(rstn_in), .link(lk), .read_param_in(rprm),
		.write_param_in(wprm), .acc_valid_out(a1v), .acc_write_out(a1w), .acc_block_out(), .acc_addr_out(a1a),
		.acc_mode_out(), .acc_tunnel_out(), .acc_encrypted_out(), .acc_family_out(), .data_blocks_out(d1), .err_out());
	rbc_tag u_rbc_tag_b (.clock_in(clock_in), .rstn_in(rstn_in), .link(lk2), .read_param_in(rprm),
		.write_param_in(wprm), .acc_valid_out(a2v), .acc_write_out(), .acc_block_out(a2b), .acc_addr_out(a2a),
		.acc_mode_out(a2m), .acc_tunnel_out(a2t), .acc_encrypted_out(a2e), .acc_family_out(a2f),
		.data_blocks_out(d2), .err_out(e2));
	rbc_properties u_rbc_properties (.clock_in(clock_in), .rstn_in(rstn_in), .cmd_valid(lk.cmd_valid),
		.cmd_data(lk.cmd_data), .cmd_last(lk.cmd_last), .rsp_valid(lk.rsp_valid), .rsp_data(lk.rsp_data),
		.rsp_last(lk.rsp_last), .read_param_in(rprm), .write_param_in(wprm));
	// ==========
	// access counters
	always @(posedge clock_in) begin
		if (a1v === 1'b1) begin
			n1++;
			la1 = a1a;
			lw1 = a1w;
		end
		if (a2v === 1'b1) begin
			n2++;
			la2 = a2a;
			lb2 = a2b;
		end
		if (e2 === 1'b1) begin
			ne++;
		end
	end
	// ==========
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock_in);
		wr <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock_in);
		rd <= 1'b0;
		@(negedge clock_in);
		d = rdata;
	endtask
	task automatic rcmd(input logic [31:0] shape, input logic [31:0] ctrl, output logic [31:0] st);
		int i;
		wrr(REG_SHAPE, shape);
		wrr(REG_CTRL, ctrl);
		st = 32'h0;
		for (i = 0; i < 300 && st[1] !== 1'b1; i++) rdr(REG_STATUS, st);
	endtask
	task automatic raw(input logic [7:0] k, input int ns, input logic diff, input int nb, input logic [7:0] hd,
		input logic [7:0] md, input logic [7:0] mdl, input logic [7:0] est);
		logic [7:0] q[$];
		int i, b1, b2;
		q = {k, 8'(ns)};
		for (i = 0; i < ns; i++) begin
			q.push_back(8'h34);
			q.push_back((diff && i == ns - 1) ? 8'h99 : 8'h12);
		end
		q.push_back(8'(nb));
		for (i = 0; i < nb; i++) begin
			q.push_back(hd);
			q.push_back(8'h20 + 8'(i));
			if (!hd[7]) q.push_back(i == nb - 1 ? mdl : md);
		end
		b1 = n2;
		b2 = ne;
		for (i = 0; i < q.size(); i++) begin
			@(posedge clock_in);
			lk2.cmd_valid <= 1'b1;
			lk2.cmd_data <= q[i];
			lk2.cmd_last <= (i == q.size() - 1);
		end
		@(posedge clock_in);
		lk2.cmd_valid <= 1'b0;
		lk2.cmd_last <= 1'b0;
		lk2.cmd_data <= ~q[q.size() - 1];
		for (i = 0; i < 40 && lk2.rsp_valid !== 1'b1; i++) @(negedge clock_in);
		@(negedge clock_in);
		chk(32'(lk2.rsp_data), 32'(est));
		for (i = 0; i < 400 && lk2.rsp_last !== 1'b1; i++) @(negedge clock_in);
		chk(32'(n2 - b1), est == 8'h00 ? 32'(nb) : 32'h0);
		chk(32'(ne - b2), est == 8'h00 ? 32'h0 : 32'h1);
	endtask
	task automatic finish_test;
		$display("checks=%0d errors=%0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// ==========
	// tests
	initial begin
		repeat (40000) @(posedge clock_in);
		err_total++;
		finish_test();
	end
	initial begin
		lk2.cmd_valid = 1'b0;
		lk2.cmd_data = 8'h00;
		lk2.cmd_last = 1'b0;
		repeat (20) @(posedge clock_in);
		rstn_in <= 1'b1;
		rdr(REG_STATUS, r);
		chk(r, 32'h0);
		rcmd(32'h0, 32'h0301, r);
		chk(32'(r[15:0]), 32'h2);
		rdr(REG_TIMING, r);
		chk(r, 32'h0001475a);
		b = n1;
		rcmd(32'h10000f0f, 32'h2, r);
		chk(32'(r[15:0]), 32'h2);
		chk(32'(n1 - b), 32'd15);
		chk(32'(la1), 32'h1e0);
		rdr(REG_TIMING, r);
		chk(32'(r[31:16]), 32'hfc);
		rcmd(32'h00060c08, 32'h3, r);
		chk(32'(r[15:0]), 32'h2);
		chk(32'({lw1, d1}), 32'h10a);
		rdr(REG_TIMING, r);
		chk(32'(r[31:16]), 32'h50);
		rdr(8'h40, r);
		chk(r, 32'h0);
		wrr(REG_SHAPE, 32'h00000110);
		wrr(REG_CTRL, 32'h2);
		rdr(REG_STATUS, r);
		chk(32'(r[3:0]), 32'h4);
		raw(CMD_READ, 15, 0, 15, 8'h8f, 8'h0, 8'h0, 8'h00);
		raw(CMD_READ, 16, 0, 1, 8'h80, 8'h0, 8'h0, 8'h01);
		raw(CMD_WRITE, 11, 0, 11, 8'h80, 8'h0, 8'h0, 8'h00);
		raw(CMD_WRITE, 12, 0, 1, 8'h80, 8'h0, 8'h0, 8'h01);
		raw(CMD_WRITE, 8, 0, 12, 8'h80, 8'h0, 8'h0, 8'h00);
		raw(CMD_WRITE, 9, 0, 12, 8'h80, 8'h0, 8'h0, 8'h10);
		raw(CMD_READ, 1, 0, 16, 8'h80, 8'h0, 8'h0, 8'h10);
		raw(CMD_READ, 2, 1, 1, 8'h80, 8'h0, 8'h0, 8'h02);
		raw(CMD_READ, 1, 0, 1, 8'h90, 8'h0, 8'h0, 8'h04);
		raw(CMD_READ, 1, 0, 2, 8'h00, 8'h08, 8'h08, 8'h04);
		raw(CMD_WRITE, 1, 0, 3, 8'h00, 8'h02, 8'h06, 8'h08);
		raw(CMD_READ, 1, 0, 2, 8'h00, 8'h02, 8'h02, 8'h10);
		raw(8'h55, 1, 0, 1, 8'h80, 8'h0, 8'h0, 8'h20);
		for (m = 0; m < 8; m++) begin
			bad = m[0] && !m[1];
			raw(CMD_READ, 1, 0, 3, 8'h00, 8'(m), 8'(m), bad ? 8'h04 : 8'h00);
			if (!bad) begin
				chk(32'({a2m, a2t, a2e, a2f}), 32'({m[2:0], m[2:0]}));
				chk(32'(d2), m[1] ? 32'h1 : 32'h3);
				chk(32'({lb2, la2}), 32'h22220);
			end
		end
		finish_test();
	end
endmodule
